/* File: pkg/cps_pkg.sv */
package cps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int PC_W  = 13;
    localparam int LAT_W = 5;
    localparam int TGT_W = 11;
    localparam int FSR_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_INDIRECT_REGISTER   = 8'h00;
    localparam logic [7:0] IDX_PC_LOW_BYTE         = 8'h02;
    localparam logic [7:0] IDX_STATUS              = 8'h03;
    localparam logic [7:0] IDX_FILE_POINTER        = 8'h04;
    localparam logic [7:0] IDX_PC_HIGH_LATCH       = 8'h0a;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL   = 8'h0b;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL_1 = 8'h8b;
    localparam logic [7:0] IDX_PERIPHERAL_FLAGS    = 8'h0c;
    localparam logic [7:0] IDX_PERIPHERAL_ENABLES  = 8'h8c;
    localparam logic [7:0] IDX_RESET_CAUSE_FLAGS   = 8'h8e;
    localparam int         BANK_BIT                = 7;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int GIE_BIT   = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT  = 6;
    localparam int T0IE_BIT  = 5;
    localparam int INTE_BIT  = 4;
    localparam int PORT_CHANGE_IRQ_ENABLE_BIT  = 3;
    localparam int TIMER_OVERFLOW_FLAG_BIT  = 2;
    localparam int EXT_PIN_IRQ_FLAG_BIT  = 1;
    localparam int PORT_CHANGE_FLAG_BIT  = 0;
    localparam int CMP_BIT   = 6;
    localparam int POR_BIT   = 1;
    localparam int BOR_BIT   = 0;
    localparam int IRP_BIT   = 7;
    localparam int TO_BIT    = 4;
    localparam int PD_BIT    = 3;
    localparam int Z_BIT     = 2;
    localparam int DC_BIT    = 1;
    localparam int C_BIT     = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]       INTERRUPT_CONTROL_RST = 8'h00;
    localparam logic             PERIPH_RST = 1'b0;
    localparam logic [LAT_W-1:0] LATCH_RST  = 5'h00;
    localparam logic [PC_W-1:0]  PC_RST     = 13'h0000;
    localparam logic [2:0]       BANK_RST   = 3'h0;
    localparam logic [FSR_W-1:0] FSR_RST    = 8'h00;
    localparam logic [PC_W-1:0]  IRQ_VECTOR = 13'h0004;

    ////////////////////////////////////////////////////////////////////////////
    // bus constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic             inc;
        logic             call;
        logic             jump;
        logic             ret;
        logic             return_from_interrupt;
        logic             vector;
        logic [TGT_W-1:0] target;
        logic             alu_we;
        logic             alu_z;
        logic             alu_dc;
        logic             alu_c;
        logic             sleep;
        logic             clrwdt;
    } cps_ctl_s;

    typedef struct packed {
        logic timer_ovf;
        logic ext_pin;
        logic port_change;
        logic comparator;
    } cps_evt_s;

    typedef struct packed {
        logic por;
        logic bor;
        logic wdt;
        logic master_clear_pin;
    } cps_cause_s;

endpackage

/* File: src/cps_stack_mem.sv */
`timescale 1ns/1ps
module cps_stack_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 13,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // write-through so a pop right after a push sees the new entry
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
    end

endmodule

/* File: src/cps_core.sv */
`timescale 1ns/1ps
module cps_core #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire cps_pkg::cps_ctl_s     ctl,
    input  wire cps_pkg::cps_evt_s     evt,
    input  wire cps_pkg::cps_cause_s   cause,
    input  wire logic                  brownout_detect_config,
    output logic [cps_pkg::PC_W-1:0]   pc,
    output logic                       irq_request,
    output logic [cps_pkg::FSR_W:0]    indirect_addr
);

    localparam int PW = cps_pkg::PC_W;
    localparam int SW = $clog2(STACK_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // bus slave state
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_idx;
    logic        next_dp_valid;
    logic        next_dp_write;
    logic [7:0]  next_dp_idx;
    logic        next_hreadyout;
    logic [31:0] next_hrdata;
    logic        take;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0]                  interrupt_control;
    logic [7:0]                  next_interrupt_control;
    logic                        cmp_flag;
    logic                        next_cmp_flag;
    logic                        cmp_enable;
    logic                        next_cmp_enable;
    logic [cps_pkg::LAT_W-1:0]   pc_high_latch;
    logic [cps_pkg::LAT_W-1:0]   next_pc_high_latch;
    logic [cps_pkg::FSR_W-1:0]   file_pointer;
    logic [cps_pkg::FSR_W-1:0]   next_file_pointer;
    logic [2:0]                  bank_bits;
    logic [2:0]                  next_bank_bits;
    logic                        st_to;
    logic                        st_pd;
    logic                        st_z;
    logic                        st_dc;
    logic                        st_c;
    logic                        next_st_to;
    logic                        next_st_pd;
    logic                        next_st_z;
    logic                        next_st_dc;
    logic                        next_st_c;
    logic                        por_flag;
    logic                        brownout_cause_flag;
    logic                        next_por_flag;
    logic                        next_brownout_cause_flag;
    logic                        cap;
    logic [PW-1:0]               next_pc;
    logic [SW-1:0]               sp;
    logic [SW-1:0]               next_sp;
    logic                        push;
    logic [PW-1:0]               stack_top;
    logic                        next_irq;
    logic                        pending;

    ////////////////////////////////////////////////////////////////////////////
    // access resolution
    logic       self_ind;
    logic       ind_null;
    logic [7:0] eff_idx;
    logic       acc_wr;
    logic [7:0] wd;
    logic [7:0] rd_val;
    logic       wr_pcl;
    logic       wr_status;
    logic       wr_fsr;
    logic       wr_latch;
    logic       wr_interrupt_control;
    logic       wr_pir;
    logic       wr_pie;
    logic       wr_reset_cause_flags;

    always_comb begin
        self_ind = dp_idx[6:0] == cps_pkg::IDX_INDIRECT_REGISTER[6:0];
        eff_idx  = self_ind ? file_pointer : dp_idx;
        ind_null = self_ind && file_pointer[6:0] == cps_pkg::IDX_INDIRECT_REGISTER[6:0];
        acc_wr   = dp_valid && dp_write && !ind_null;
        wd       = hwdata[7:0];
        wr_pcl    = acc_wr && eff_idx[6:0] == cps_pkg::IDX_PC_LOW_BYTE[6:0];
        wr_status = acc_wr && eff_idx[6:0] == cps_pkg::IDX_STATUS[6:0];
        wr_fsr    = acc_wr && eff_idx[6:0] == cps_pkg::IDX_FILE_POINTER[6:0];
        wr_latch  = acc_wr && eff_idx[6:0] == cps_pkg::IDX_PC_HIGH_LATCH[6:0];
        wr_interrupt_control = acc_wr && eff_idx[6:0] == cps_pkg::IDX_INTERRUPT_CONTROL[6:0];
        wr_pir    = acc_wr && eff_idx == cps_pkg::IDX_PERIPHERAL_FLAGS;
        wr_pie    = acc_wr && eff_idx == cps_pkg::IDX_PERIPHERAL_ENABLES;
        wr_reset_cause_flags   = acc_wr && eff_idx == cps_pkg::IDX_RESET_CAUSE_FLAGS;
        rd_val = 8'h00;
        if (!ind_null) begin
            unique case (eff_idx[6:0])
                cps_pkg::IDX_PC_LOW_BYTE[6:0]:       rd_val = pc[7:0];
                cps_pkg::IDX_STATUS[6:0]:            rd_val = {bank_bits, st_to, st_pd,
                                                               st_z, st_dc, st_c};
                cps_pkg::IDX_FILE_POINTER[6:0]:      rd_val = file_pointer;
                cps_pkg::IDX_PC_HIGH_LATCH[6:0]:     rd_val = {3'h0, pc_high_latch};
                cps_pkg::IDX_INTERRUPT_CONTROL[6:0]: rd_val = interrupt_control;
                cps_pkg::IDX_PERIPHERAL_FLAGS[6:0]: begin
                    rd_val[cps_pkg::CMP_BIT] = eff_idx[cps_pkg::BANK_BIT] ? cmp_enable
                                                                          : cmp_flag;
                end
                cps_pkg::IDX_RESET_CAUSE_FLAGS[6:0]: begin
                    if (eff_idx[cps_pkg::BANK_BIT]) begin
                        rd_val[cps_pkg::POR_BIT] = por_flag;
                        rd_val[cps_pkg::BOR_BIT] = brownout_cause_flag;
                    end
                end
                default: rd_val = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: one wait state, read data from a flop
    always_comb begin
        take           = hsel && hready && htrans == cps_pkg::HTRANS_NONSEQ;
        next_dp_valid  = take;
        next_dp_write  = hwrite;
        next_dp_idx    = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'h7f;
        next_hreadyout = !take;
        next_hrdata    = hrdata;
        if (dp_valid && !dp_write) begin
            next_hrdata = {24'h0, rd_val};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dp_valid  <= 1'b0;
            dp_write  <= 1'b0;
            dp_idx    <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0;
            hresp     <= cps_pkg::HRESP_OKAY;
        end else begin
            dp_valid  <= next_dp_valid;
            dp_write  <= next_dp_write;
            dp_idx    <= next_dp_idx;
            hreadyout <= next_hreadyout;
            hrdata    <= next_hrdata;
            hresp     <= cps_pkg::HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt enables and flags; an event beats a clearing write
    always_comb begin
        next_interrupt_control     = wr_interrupt_control ? wd : interrupt_control;
        next_cmp_flag   = wr_pir ? wd[cps_pkg::CMP_BIT] : cmp_flag;
        next_cmp_enable = wr_pie ? wd[cps_pkg::CMP_BIT] : cmp_enable;
        if (ctl.vector) begin
            next_interrupt_control[cps_pkg::GIE_BIT] = 1'b0;
        end else if (ctl.return_from_interrupt) begin
            next_interrupt_control[cps_pkg::GIE_BIT] = 1'b1;
        end
        if (evt.timer_ovf) next_interrupt_control[cps_pkg::TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
        if (evt.ext_pin) next_interrupt_control[cps_pkg::EXT_PIN_IRQ_FLAG_BIT] = 1'b1;
        if (evt.port_change) next_interrupt_control[cps_pkg::PORT_CHANGE_FLAG_BIT] = 1'b1;
        if (evt.comparator) next_cmp_flag = 1'b1;
        pending = interrupt_control[cps_pkg::GIE_BIT] && (
                  (interrupt_control[cps_pkg::T0IE_BIT] && interrupt_control[cps_pkg::TIMER_OVERFLOW_FLAG_BIT])
               || (interrupt_control[cps_pkg::INTE_BIT] && interrupt_control[cps_pkg::EXT_PIN_IRQ_FLAG_BIT])
               || (interrupt_control[cps_pkg::PORT_CHANGE_IRQ_ENABLE_BIT] && interrupt_control[cps_pkg::PORT_CHANGE_FLAG_BIT])
               || (interrupt_control[cps_pkg::PERIPHERAL_IRQ_ENABLE_BIT] && cmp_enable && cmp_flag));
        next_irq = pending;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_control      <= cps_pkg::INTERRUPT_CONTROL_RST;
            cmp_flag    <= cps_pkg::PERIPH_RST;
            cmp_enable  <= cps_pkg::PERIPH_RST;
            irq_request <= 1'b0;
        end else begin
            interrupt_control      <= next_interrupt_control;
            cmp_flag    <= next_cmp_flag;
            cmp_enable  <= next_cmp_enable;
            irq_request <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter and return stack
    always_comb begin
        next_pc = pc;
        next_sp = sp;
        push    = 1'b0;
        if (ctl.vector) begin
            push    = 1'b1;
            next_pc = cps_pkg::IRQ_VECTOR;
        end else if (ctl.call || ctl.jump) begin
            push    = ctl.call;
            next_pc = {pc_high_latch[4:3], ctl.target};
        end else if (ctl.ret || ctl.return_from_interrupt) begin
            next_sp = SW'(sp - 1'b1);
            next_pc = stack_top;
        end else if (wr_pcl) begin
            next_pc = {pc_high_latch, wd};
        end else if (ctl.inc) begin
            next_pc = PW'(pc + 1'b1);
        end
        if (push) begin
            next_sp = SW'(sp + 1'b1);
        end
        next_pc_high_latch = wr_latch ? wd[cps_pkg::LAT_W-1:0] : pc_high_latch;
        next_file_pointer  = wr_fsr ? wd : file_pointer;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc            <= cps_pkg::PC_RST;
            sp            <= '0;
            pc_high_latch <= cps_pkg::LATCH_RST;
            file_pointer  <= cps_pkg::FSR_RST;
            indirect_addr <= '0;
        end else begin
            pc            <= next_pc;
            sp            <= next_sp;
            pc_high_latch <= next_pc_high_latch;
            file_pointer  <= next_file_pointer;
            indirect_addr <= {bank_bits[2], next_file_pointer};
        end
    end

    cps_stack_mem #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PW),
        .AW    (SW)
    ) u_stack (
        .clk   (clk),
        .we    (push),
        .waddr (sp),
        .wdata (pc),
        .raddr (SW'(next_sp - 1'b1)),
        .rdata (stack_top)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status and reset cause; cause flags survive resets, caught while reset is held and on the first clock after release
    always_comb begin
        next_bank_bits = wr_status ? wd[7:5] : bank_bits;
        next_st_z  = st_z;
        next_st_dc = st_dc;
        next_st_c  = st_c;
        if (ctl.alu_we) begin
            next_st_z  = ctl.alu_z;
            next_st_dc = ctl.alu_dc;
            next_st_c  = ctl.alu_c;
        end else if (wr_status) begin
            next_st_z  = wd[cps_pkg::Z_BIT];
            next_st_dc = wd[cps_pkg::DC_BIT];
            next_st_c  = wd[cps_pkg::C_BIT];
        end
        next_st_to = st_to;
        next_st_pd = st_pd;
        next_por_flag            = wr_reset_cause_flags ? wd[cps_pkg::POR_BIT] : por_flag;
        next_brownout_cause_flag = wr_reset_cause_flags ? wd[cps_pkg::BOR_BIT] : brownout_cause_flag;
        if (cap) begin
            if (cause.por) begin
                next_por_flag = 1'b0;
                next_st_to    = 1'b1;
                next_st_pd    = 1'b1;
            end else if (cause.bor) begin
                if (brownout_detect_config) next_brownout_cause_flag = 1'b0;
            end else if (cause.wdt) begin
                next_st_to = 1'b0;
            end
        end else if (ctl.clrwdt) begin
            next_st_to = 1'b1;
            next_st_pd = 1'b1;
        end else if (ctl.sleep) begin
            next_st_to = 1'b1;
            next_st_pd = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_bits <= cps_pkg::BANK_RST;
            cap       <= 1'b1;
        end else begin
            bank_bits <= next_bank_bits;
            cap       <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st_z                <= next_st_z;
        st_dc               <= next_st_dc;
        st_c                <= next_st_c;
        st_to               <= next_st_to;
        st_pd               <= next_st_pd;
        por_flag            <= next_por_flag;
        brownout_cause_flag <= next_brownout_cause_flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_call;
        ctl.call && !ctl.vector;
    endsequence

    sequence s_pop;
        (ctl.ret || ctl.return_from_interrupt) && !ctl.vector && !ctl.call && !ctl.jump;
    endsequence

    irq_gate_a: assert property (!pending |=> !irq_request)
        else $error("interrupt requested without enabled pending source");
    irq_raise_a: assert property (pending |=> irq_request)
        else $error("pending interrupt not requested");
    flag_set_a: assert property (evt.timer_ovf |=> interrupt_control[cps_pkg::TIMER_OVERFLOW_FLAG_BIT])
        else $error("timer flag not set by event");
    cmp_set_a: assert property (evt.comparator ##1 1'b1 |-> cmp_flag)
        else $error("comparator flag not set by event");
    pcl_load_a: assert property (wr_pcl && !ctl.vector && !ctl.call && !ctl.jump
        && !ctl.ret && !ctl.return_from_interrupt |=> pc == {$past(pc_high_latch), $past(wd)})
        else $error("low byte write did not load latch bits");
    call_load_a: assert property (s_call |=> pc[12:11] == $past(pc_high_latch[4:3])
        && pc[10:0] == $past(ctl.target))
        else $error("call target wrongly formed");
    stack_round_a: assert property (s_call ##1 s_pop |=> pc == $past(pc, 2)
        && $stable(pc_high_latch))
        else $error("return did not restore pushed address");
    stack_wrap_a: assert property (push |=> sp == SW'($past(sp) + 1'b1))
        else $error("stack pointer did not advance circularly");
    indirect_register_self_a: assert property (dp_valid && !dp_write && ind_null |=> hrdata == 32'h0)
        else $error("self indirect read not zero");
    status_keep_a: assert property (wr_status && ctl.alu_we |=> st_z == $past(ctl.alu_z))
        else $error("status write overrode instruction flag");
    to_pd_a: assert property (!cap && !ctl.sleep && !ctl.clrwdt |=> $stable(st_to)
        && $stable(st_pd))
        else $error("time-out or power-down bit changed");
    pc_reset_a: assert property (@(posedge clk) disable iff (1'b0) rst |-> pc == 13'h0000)
        else $error("program counter not cleared by reset");

endmodule

/* File: test/cps_cpu_model.sv */
`timescale 1ns/1ps
module cps_cpu_model (
    input  wire logic         clk,
    output cps_pkg::cps_ctl_s ctl,
    output cps_pkg::cps_evt_s evt
);
    initial begin
        ctl = '0;
        evt = '0;
    end

    // one-cycle strobe, returns once the answer has landed
    task automatic strobe(input cps_pkg::cps_ctl_s c, input cps_pkg::cps_evt_s e);
        @(posedge clk);
        ctl <= c;
        evt <= e;
        @(posedge clk);
        ctl <= '0;
        evt <= '0;
        #1;
    endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic                clk;
    logic                rst;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    cps_pkg::cps_ctl_s   ctl;
    cps_pkg::cps_evt_s   evt;
    cps_pkg::cps_cause_s cause;
    logic                bo_cfg;
    logic [12:0]         pc;
    logic                irq;
    logic [8:0]          ind_addr;
    logic [7:0]          rd;
    int                  error_cnt;
    int                  checks;

    cps_core cps_core_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ctl(ctl), .evt(evt), .cause(cause), .brownout_detect_config(bo_cfg),
        .pc(pc), .irq_request(irq), .indirect_addr(ind_addr));
    cps_cpu_model cps_cpu_model_inst (.clk(clk), .ctl(ctl), .evt(evt));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= cps_pkg::HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask

    task automatic cpu(input logic call, input logic ret, input logic [10:0] t);
        cps_pkg::cps_ctl_s c;
        c = '0;
        c.call = call;
        c.ret = ret;
        c.target = t;
        cps_cpu_model_inst.strobe(c, '0);
    endtask

    task automatic do_reset(input cps_pkg::cps_cause_s c);
        @(posedge clk);
        rst <= 1'b1;
        cause <= c;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        cause <= '0;
    endtask

    task automatic test_regs();
        bus(0, cps_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
        chk("interrupt_control rst", rd, 8'h00);
        bus(1, cps_pkg::IDX_INTERRUPT_CONTROL, 8'h28);
        bus(0, cps_pkg::IDX_INTERRUPT_CONTROL_1, 8'h00);
        chk("interrupt_control mirror", rd, 8'h28);
        bus(0, cps_pkg::IDX_PERIPHERAL_FLAGS, 8'h00);
        chk("pflags rst", rd, 8'h00);
        bus(1, cps_pkg::IDX_PERIPHERAL_ENABLES, 8'hff);
        bus(0, cps_pkg::IDX_PERIPHERAL_ENABLES, 8'h00);
        chk("penables", rd, 8'h40);
        bus(0, 8'h0d, 8'h00);
        chk("unmapped", rd, 8'h00);
        chk("hresp", 16'(hresp), 16'(cps_pkg::HRESP_OKAY));
        $display("test regs done");
    endtask

    task automatic test_events();
        bus(1, cps_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
        bus(1, cps_pkg::IDX_PERIPHERAL_ENABLES, 8'h00);
        cps_cpu_model_inst.strobe('0, 4'hf);
        bus(0, cps_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
        chk("flags", rd, 8'h07);
        bus(0, cps_pkg::IDX_PERIPHERAL_FLAGS, 8'h00);
        chk("cmp flag", rd, 8'h40);
        bus(1, cps_pkg::IDX_INTERRUPT_CONTROL, 8'hc7);
        @(posedge clk);
        #1;
        chk("irq masked", 16'(irq), 16'h0);
        bus(1, cps_pkg::IDX_PERIPHERAL_ENABLES, 8'h40);
        @(posedge clk);
        #1;
        chk("irq periph", 16'(irq), 16'h1);
        $display("test events done");
    endtask

    task automatic test_pc();
        chk("pc rst", 16'(pc), 16'h0);
        bus(1, cps_pkg::IDX_PC_HIGH_LATCH, 8'h15);
        bus(1, cps_pkg::IDX_PC_LOW_BYTE, 8'h3c);
        @(posedge clk);
        #1;
        chk("pc load", 16'(pc), 16'h153c);
        bus(0, cps_pkg::IDX_PC_LOW_BYTE, 8'h00);
        chk("pc low", rd, 8'h3c);
        bus(1, cps_pkg::IDX_PC_HIGH_LATCH, 8'h18);
        for (int i = 1; i <= 9; i++) begin
            cpu(1, 0, 11'(i * 37));
            chk("call pc", 16'(pc), {3'h0, 2'h3, 11'(i * 37)});
        end
        // ninth push replaced the oldest entry, so pops wrap back to it
        for (int i = 8; i >= 0; i--) begin
            cpu(0, 1, 11'h0);
            chk("ret pc", 16'(pc), {3'h0, 2'h3, 11'((i == 0 ? 8 : i) * 37)});
        end
        bus(0, cps_pkg::IDX_PC_HIGH_LATCH, 8'h00);
        chk("latch kept", rd, 8'h18);
        $display("test pc done");
    endtask

    task automatic test_indirect();
        bus(1, cps_pkg::IDX_FILE_POINTER, 8'h0b);
        chk("ind addr", 16'(ind_addr), 16'h000b);
        bus(1, cps_pkg::IDX_INTERRUPT_CONTROL, 8'h30);
        bus(0, cps_pkg::IDX_INDIRECT_REGISTER, 8'h00);
        chk("ind read", rd, 8'h30);
        bus(1, cps_pkg::IDX_INDIRECT_REGISTER, 8'h08);
        bus(0, cps_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
        chk("ind write", rd, 8'h08);
        bus(1, cps_pkg::IDX_FILE_POINTER, 8'h00);
        bus(1, cps_pkg::IDX_INDIRECT_REGISTER, 8'h55);
        bus(0, cps_pkg::IDX_INDIRECT_REGISTER, 8'h00);
        chk("ind self", rd, 8'h00);
        $display("test indirect done");
    endtask

    task automatic test_core();
        cps_pkg::cps_ctl_s c;
        c = '0;
        c.alu_we = 1'b1;
        c.alu_z = 1'b1;
        c.alu_c = 1'b1;
        fork
            bus(1, cps_pkg::IDX_STATUS, 8'h02);
            begin
                @(posedge clk);
                cps_cpu_model_inst.strobe(c, '0);
            end
        join
        bus(0, cps_pkg::IDX_STATUS, 8'h00);
        chk("status alu", rd, 8'h1d);
        c = '0;
        c.sleep = 1'b1;
        cps_cpu_model_inst.strobe(c, '0);
        bus(1, cps_pkg::IDX_STATUS, 8'hff);
        bus(0, cps_pkg::IDX_STATUS, 8'h00);
        chk("status ro", rd, 8'hf7);
        bus(1, cps_pkg::IDX_STATUS, 8'h00);
        bus(1, cps_pkg::IDX_PC_LOW_BYTE, 8'h11);
        c = '0;
        c.vector = 1'b1;
        cps_cpu_model_inst.strobe(c, '0);
        chk("vector pc", 16'(pc), 16'(cps_pkg::IRQ_VECTOR));
        c = '0;
        c.return_from_interrupt = 1'b1;
        cps_cpu_model_inst.strobe(c, '0);
        chk("return_from_interrupt pc", 16'(pc), 16'h1811);
        c = '0;
        c.jump = 1'b1;
        c.target = 11'h055;
        cps_cpu_model_inst.strobe(c, '0);
        chk("jump pc", 16'(pc), 16'h1855);
        c = '0;
        c.inc = 1'b1;
        cps_cpu_model_inst.strobe(c, '0);
        chk("inc pc", 16'(pc), 16'h1856);
        $display("test core done");
    endtask

    task automatic test_cause();
        bus(0, cps_pkg::IDX_RESET_CAUSE_FLAGS, 8'h00);
        chk("por flag", 16'(rd[1]), 16'h0);
        bus(1, cps_pkg::IDX_RESET_CAUSE_FLAGS, 8'h03);
        do_reset(4'b0100);
        chk("pc bor", 16'(pc), 16'h0);
        bus(0, cps_pkg::IDX_RESET_CAUSE_FLAGS, 8'h00);
        chk("bor flag", rd, 8'h02);
        $display("test cause done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        cause = 4'b1000;
        bo_cfg = 1'b1;
        error_cnt = 0;
        checks = 0;
        do_reset(4'b1000);
        test_pc();
        test_regs();
        test_events();
        test_indirect();
        test_core();
        test_cause();
        stop_test();
    end
endmodule
